// [include/adcs_pkg.sv]
// Shared constants and types for the converter serial interface block
package adcs_pkg;

	// Clock and conversion timing
	localparam int CLK_PERIOD_NS = 25;                 // pclk period at 40 MHz
	localparam int CONV_TIME_NS  = 500;                // Internal conversion duration
	localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Result and frame layout
	localparam int          RESULT_BITS    = 16;
	localparam logic [4:0]  FRAME_PLAIN    = 5'h10;    // Result bits only
	localparam logic [4:0]  FRAME_BUSY     = 5'h11;    // Start bit plus result
	localparam logic        START_BIT_SEL  = 1'b0;     // Select mode start bit level
	localparam logic        START_BIT_CHN  = 1'b1;     // Chain mode start bit level
	localparam logic [15:0] CODE_ALL_ONES  = 16'hFFFF;
	localparam logic [15:0] CODE_ALL_ZEROS = 16'h0000;

	// Register byte offsets
	localparam logic [7:0] OFS_SAMPLE     = 8'h00;
	localparam logic [7:0] OFS_RESULT     = 8'h04;
	localparam logic [7:0] OFS_STATUS     = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;

	// Reset values
	localparam logic [17:0] SAMPLE_RESET = 18'h00000;
	localparam logic [2:0]  IRQ_EN_RESET = 3'h0;

	// Status register bit positions
	localparam int ST_CONVERTING = 0;
	localparam int ST_POWER_DOWN = 1;
	localparam int ST_MODE_VALID = 2;
	localparam int ST_CHAIN      = 3;
	localparam int ST_BUSY_EN    = 4;
	localparam int ST_FOUR_WIRE  = 5;
	localparam int ST_DRIVING    = 6;

	// Pins arriving from the host
	typedef struct packed {
		logic convert_start;
		logic sck;
		logic serial_data_in;
	} adcs_pins_t;

	// Analog stand-in written by software
	typedef struct packed {
		logic        under;
		logic        over;
		logic [15:0] code;
	} adcs_sample_t;

	// Interrupt events, same layout in status, enable and clear
	typedef struct packed {
		logic mode_latched;
		logic frame_done;
		logic conv_done;
	} adcs_evt_t;

	// Converter phase
	typedef enum logic [0:0] {
		ACQUIRE,
		CONVERT
	} adcs_phase_t;

endpackage

// [src/adcs_sync.sv]
// Two-stage synchroniser for the host pins
module adcs_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Asynchronous and synchronised levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta;     // First stage, read only by the second

	// Both stages reset to low; pins settle within two cycles after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// [src/adcs_conv.sv]
// Conversion timer and output code generation
module adcs_conv
	import adcs_pkg::*;
#(
	parameter int CYCLES = CONV_CYCLES
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control
	input  wire logic         start,
	input  adcs_pkg::adcs_sample_t sample,
	// Completion
	output logic              done,
	output logic       [15:0] result
);

	logic [15:0] remaining;   // Cycles left in the running conversion
	logic        running;     // Conversion in progress

	// Straight binary with clamping at both ends
	function automatic logic [15:0] clamp_code(input adcs_sample_t s);
		if (s.over)
			return CODE_ALL_ONES;
		else if (s.under)
			return CODE_ALL_ZEROS;
		else
			return s.code;
	endfunction

	// Internal clock count; needs no serial clock at all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remaining <= 16'h0000;
			running   <= 1'b0;
			done      <= 1'b0;
			result    <= 16'h0000;
		end else begin
			done <= 1'b0;
			if (start && !running) begin
				running   <= 1'b1;
				remaining <= 16'(CYCLES - 1);
				result    <= clamp_code(sample);   // Input held at conversion start
			end else if (running) begin
				if (remaining == 16'h0000) begin
					running <= 1'b0;
					done    <= 1'b1;
				end else begin
					remaining <= remaining - 16'h0001;
				end
			end
		end
	end

endmodule

// [src/adcs_top.sv]
// Converter digital interface: mode latch, busy start bit, serial readout, APB registers
//
// Operation
// - Data input level at start edge picks mode
// - Tied data input and start give chain
// - Optional start bit ahead of result
// - Select mode: busy if start/data low
// - Chain mode: busy if clock high at start
// - Power down after every conversion
// - Three-wire: start line also selects readout
// - Four-wire: data input selects readout
// - Chain mode shifts upstream data through
// - Start edge begins internally clocked conversion
// - Straight binary, clamped at both ends
// - MSB first, advance on clock falling
module adcs_top
	import adcs_pkg::*;
#(
	parameter int CYCLES = CONV_CYCLES
) (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Host serial pins
	input  wire logic        convert_start,
	input  wire logic        sck,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_out_oe,
	// Interrupt
	output logic             irq
);

	// Pin side: raw, synchronised and delayed copies
	adcs_pins_t   pins_raw;       // Pins as they arrive
	adcs_pins_t   pins_s;         // Synchronised pins
	adcs_pins_t   pins_d;         // Synchronised pins, one cycle older
	// Converter and register state
	adcs_phase_t  phase;          // Acquire or convert
	adcs_sample_t sample;         // Software stand-in for the analog input
	adcs_evt_t    irq_status;     // Sticky events
	adcs_evt_t    irq_enable;     // Event mask
	adcs_evt_t    evt;            // Events raised this cycle
	adcs_evt_t    clr;            // Clear pulse from software
	// Edge strobes, each one pclk wide, and the converter codes
	logic         cnv_rise;       // Start edge seen
	logic         sck_rise;       // Serial clock rising
	logic         sck_fall;       // Serial clock falling
	logic         accept;         // Start edge that begins a conversion
	logic         conv_done;      // Conversion finished
	logic [15:0]  conv_result;    // Code from the converter
	logic [15:0]  result;         // Last completed code, for software
	// Mode decisions taken at each accepted start edge or, for select mode, at conversion end
	logic         mode_valid;     // A mode has been latched
	logic         chain;          // Chain mode, else select mode
	logic         busy_en;        // Start bit inserted
	logic         four_wire;      // Select mode using data input as select
	logic         powered_down;   // Idle after a conversion
	// Readout frame
	logic         frame_valid;    // A result waits to be read
	logic [16:0]  shreg;          // Output frame, MSB leaves first
	logic [4:0]   bits_left;      // Shift positions left in the frame
	logic         sdi_cap;        // Upstream bit caught on clock rising
	logic         selected;       // Readout select active
	logic         drive;          // Output pin should be driven
	// APB decode
	logic         wr_en;          // APB write takes effect
	logic         rd_en;          // APB read answer is prepared
	logic         mapped;         // Address decodes to a register
	logic [31:0]  rd_mux;         // Read data for the current address

	// Gather the three host pins into one carrier
	assign pins_raw = '{convert_start: convert_start, sck: sck, serial_data_in: serial_data_in};

	// Pins come from the host's domain, so they pass two flip-flops first
	adcs_sync #(
		.W($bits(adcs_pins_t))
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	// One more stage gives edge detection and the pre-edge levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_d <= '0;
		end else begin
			pins_d <= pins_s;
		end
	end

	// Edge strobes compare the newest synchronised sample with the one before;
	// a pin level must hold one pclk to be seen, so the host clock is assumed
	// to be far slower than pclk
	assign cnv_rise = pins_s.convert_start & ~pins_d.convert_start;
	assign sck_rise = pins_s.sck & ~pins_d.sck;
	assign sck_fall = ~pins_s.sck & pins_d.sck;
	// Edges during a conversion are ignored: it runs to completion
	assign accept   = cnv_rise && (phase == ACQUIRE);

	// Internally timed conversion
	adcs_conv #(
		.CYCLES(CYCLES)
	) u_conv (
		.pclk   (pclk),
		.presetn(presetn),
		.start  (accept),
		.sample (sample),
		.done   (conv_done),
		.result (conv_result)
	);

	// Phase tracking; idle after reset with no mode chosen
	// The timer owns the duration; this keeps the last code for software,
	// so a read never sees a half-finished result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase        <= ACQUIRE;
			powered_down <= 1'b0;
			result       <= 16'h0000;
		end else if (accept) begin
			phase        <= CONVERT;
			powered_down <= 1'b0;
		end else if (conv_done) begin
			phase        <= ACQUIRE;
			powered_down <= 1'b1;
			result       <= conv_result;
		end
	end

	// Mode latch at the start edge
	// The mode holds until the next accepted start edge, so a late readout
	// still follows the mode of its own conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_valid <= 1'b0;
			chain      <= 1'b0;
		end else if (accept) begin
			mode_valid <= 1'b1;
			// The older sample models input hold: a data input tied to
			// the start line still reads low here
			chain      <= ~pins_d.serial_data_in;
		end
	end

	// Busy start bit decision
	// Four-wire is only a hint for software: with busy off, both select
	// forms look alike when the conversion ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_en   <= 1'b0;
			four_wire <= 1'b0;
		end else if (accept) begin
			// Chain decides at the start edge from the clock level
			busy_en <= ~pins_d.serial_data_in & pins_d.sck;
		end else if (conv_done && !chain) begin
			// Select decides when the conversion ends
			busy_en   <= ~pins_s.convert_start | ~pins_s.serial_data_in;
			// Start line still high means it is not the readout select
			four_wire <= pins_s.convert_start;
		end
	end

	// Readout select: in select mode either line low selects, since the
	// unused one is held high; chain reads while the start line is low
	// Limitation: a chain device has no readout select of its own
	always_comb begin
		if (chain)
			selected = ~pins_s.convert_start;
		else
			selected = ~pins_s.convert_start | ~pins_s.serial_data_in;
	end

	// In select mode the frame ends after its last bit; chain keeps shifting
	// so upstream data can pass through
	// Trade-off: a select frame stops at its count even if the host keeps
	// clocking, which frees a shared data line for the next device
	assign drive = frame_valid && selected && (phase == ACQUIRE)
	               && (chain || bits_left != 5'h00);

	// Upstream bit caught on the rising edge, shifted in on the falling
	// Taking it on the rise gives the upstream device a full half period
	// to settle its own output first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdi_cap <= 1'b0;
		end else if (sck_rise) begin
			sdi_cap <= pins_s.serial_data_in;
		end
	end

	// Frame loading and shifting
	// Priority: start edge, then load at conversion end, then deselect,
	// then shifting; load and shift never meet in one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_valid <= 1'b0;
			shreg       <= 17'h00000;
			bits_left   <= 5'h00;
		end else if (accept) begin
			frame_valid <= 1'b0;   // A new conversion discards an unread one
		end else if (conv_done) begin
			frame_valid <= 1'b1;
			if (busy_en || (!chain && (~pins_s.convert_start | ~pins_s.serial_data_in))) begin
				shreg     <= {chain ? START_BIT_CHN : START_BIT_SEL, conv_result};
				bits_left <= FRAME_BUSY;
			end else begin
				shreg     <= {conv_result, 1'b0};
				bits_left <= FRAME_PLAIN;
			end
		end else if (frame_valid && !selected && !chain && bits_left != load_len(busy_en)) begin
			frame_valid <= 1'b0;   // Deselect mid-frame ends a select-mode readout
		end else if (drive && sck_fall) begin
			// A plain frame has a spare low bit under the result; upstream data
			// goes in above it so it follows the sixteenth bit directly
			if (chain && !busy_en)
				shreg <= {shreg[15:1], sdi_cap, 1'b0};
			else
				shreg <= {shreg[15:0], chain ? sdi_cap : 1'b0};
			if (bits_left != 5'h00)
				bits_left <= bits_left - 5'h01;
		end
	end

	// Frame length for a given start bit choice
	function automatic logic [4:0] load_len(input logic with_start);
		return with_start ? FRAME_BUSY : FRAME_PLAIN;
	endfunction

	// Pin drivers, one cycle behind the internal decision
	// Registered so the pin never glitches while the select decode settles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_data_out    <= 1'b0;
			serial_data_out_oe <= 1'b0;
		end else begin
			serial_data_out    <= drive ? shreg[16] : 1'b0;
			serial_data_out_oe <= drive;
		end
	end

	// Events
	// Each is a one-cycle strobe; the sticky register keeps it
	always_comb begin
		evt.conv_done    = conv_done;
		evt.mode_latched = accept;
		evt.frame_done   = drive && sck_fall && (bits_left == 5'h01);
	end

	// APB handshake: one wait state, then the answer
	// Reads are prepared in the first access cycle and answered in the
	// second, so every transfer takes exactly one wait state
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && penable && !pready;

	// Address decode
	// Unmapped offsets answer with an error and leave every register alone
	function automatic logic is_mapped(input logic [7:0] a);
		return a == OFS_SAMPLE || a == OFS_RESULT || a == OFS_STATUS ||
		       a == OFS_IRQ_STATUS || a == OFS_IRQ_ENABLE || a == OFS_IRQ_CLEAR;
	endfunction

	assign mapped = is_mapped(paddr);
	assign clr    = (wr_en && paddr == OFS_IRQ_CLEAR) ? adcs_evt_t'(pwdata[2:0]) : '0;

	// Read multiplexer; clear register reads as zero
	// Status bits show live state, so software may poll during readout
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (paddr)
			OFS_SAMPLE:     rd_mux[17:0] = sample;
			OFS_RESULT:     rd_mux[15:0] = result;
			OFS_STATUS: begin
				rd_mux[ST_CONVERTING] = (phase == CONVERT);
				rd_mux[ST_POWER_DOWN] = powered_down;
				rd_mux[ST_MODE_VALID] = mode_valid;
				rd_mux[ST_CHAIN]      = chain;
				rd_mux[ST_BUSY_EN]    = busy_en;
				rd_mux[ST_FOUR_WIRE]  = four_wire;
				rd_mux[ST_DRIVING]    = serial_data_out_oe;
			end
			OFS_IRQ_STATUS: rd_mux[2:0] = irq_status;
			OFS_IRQ_ENABLE: rd_mux[2:0] = irq_enable;
			default:        rd_mux = 32'h00000000;
		endcase
	end

	// APB answer registers
	// Read data returns to zero between answers, so no stale word shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= rd_en;
			prdata  <= (rd_en && !pwrite) ? rd_mux : 32'h00000000;
			pslverr <= rd_en && !mapped;
		end
	end

	// Software-written registers
	// A new sample applies from the next accepted start edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample     <= SAMPLE_RESET;
			irq_enable <= IRQ_EN_RESET;
		end else if (wr_en) begin
			if (paddr == OFS_SAMPLE)
				sample <= pwdata[17:0];
			if (paddr == OFS_IRQ_ENABLE)
				irq_enable <= pwdata[2:0];
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~clr) | evt;
		end
	end

	// Level interrupt from enabled sticky bits
	// Built from the next status value so the output is not a cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irq_status & ~clr | evt) & irq_enable);
		end
	end

endmodule

// [test/adcs_top_assertions.sv]
// Port-level assertions for the converter interface block
module adcs_top_assertions
	import adcs_pkg::*;
#(
	parameter int CYCLES = CONV_CYCLES
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Serial pins and interrupt
	input wire logic        convert_start,
	input wire logic        sck,
	input wire logic        serial_data_in,
	input wire logic        serial_data_out,
	input wire logic        serial_data_out_oe,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       started;  // Start line seen high since reset
	logic       sck_q;    // Last raw clock sample
	logic [3:0] fall_age; // Cycles since the clock fell
	logic [3:0] sel_age;  // Cycles since a select level
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Ages saturate, so a long idle never wraps into a false pass
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			started  <= 1'b0;
			sck_q    <= 1'b0;
			fall_age <= 4'hF;
			sel_age  <= 4'hF;
		end else begin
			started  <= started | convert_start;
			sck_q    <= sck;
			fall_age <= (sck_q && !sck) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
			sel_age  <= (!convert_start || !serial_data_in) ? 4'h0 : sel_age + {3'h0, sel_age != 4'hF};
		end
	end
	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	reset_quiet_a: assert property (!started |-> !serial_data_out_oe)
		else $error("output driven before any start");
	data_zero_a: assert property (!serial_data_out_oe |-> !serial_data_out)
		else $error("data high while released");
	deselect_off_a: assert property ((convert_start && serial_data_in) [*6] |-> !serial_data_out_oe)
		else $error("output driven while deselected");
	select_cause_a: assert property ($rose(serial_data_out_oe) |-> sel_age <= 4'h6)
		else $error("output driven without select");
	shift_fall_a: assert property (serial_data_out_oe && $past(serial_data_out_oe) && $changed(serial_data_out)
		|-> fall_age <= 4'h7)
		else $error("data moved without a clock fall");
	oe_rise_c: cover property ($rose(serial_data_out_oe));
	slverr_c: cover property (pslverr);
	irq_c: cover property ($rose(irq));
endmodule
bind adcs_top adcs_top_assertions #(.CYCLES(CYCLES)) adcs_top_assertions_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.convert_start(convert_start), .sck(sck), .serial_data_in(serial_data_in),
	.serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe), .irq(irq));

// [test/adcs_host.sv]
// Behavioural serial host: drives start, clock and data input, reads the line
module adcs_host (
	// Clock
	input  wire logic pclk,
	// Pins towards the converter
	output logic      convert_start,
	output logic      sck,
	output logic      serial_data_in,
	// Data line as resolved with its pull-up
	input  wire logic sdo_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	// Move all three pins together just after an edge
	task automatic pins(input logic c, input logic s, input logic d);
		@(posedge pclk);
		convert_start  <= c;
		sck            <= s;
		serial_data_in <= d;
	endtask
	// Hold the pins for n edges; the clock stands still meanwhile
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// 200 ns clock; sample late in the high half, upstream bits leave on the rise
	task automatic shift(input int n, input logic [47:0] up, output logic [47:0] got);
		got = 48'h0;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			sck            <= 1'b1;
			serial_data_in <= up[n-1-i];
			idle(4);
			got = {got[46:0], sdo_wire};
			sck <= 1'b0;
			idle(3);
		end
	endtask
endmodule

// [test/adcs_top_tb.sv]
// Self-checking bench for the converter interface block
`define CHK(nm, ex, sn) \
	begin \
		check_count++; \
		if ((sn) !== (ex)) begin \
			mismatches++; \
			$display("unexpected %s expected %h seen %h", nm, ex, sn); \
		end \
	end
module adcs_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import adcs_pkg::*;
	localparam int          CYC  = 8;        // Short conversion keeps runs brief
	localparam logic [15:0] CODE = 16'hA5C3; // Sample used for readout
	logic        pclk        = 1'b0;
	logic        presetn     = 1'b0;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        convert_start;
	logic        sck;
	logic        serial_data_in;
	logic        serial_data_out;
	logic        serial_data_out_oe;
	logic        irq;
	logic        sdo_wire;
	int          mismatches  = 0;
	int          check_count = 0;
	// Pull-up on the data line when released
	assign sdo_wire = serial_data_out_oe ? serial_data_out : 1'b1;
	// 40 MHz clock
	always #12.5 pclk = ~pclk;
	adcs_top #(.CYCLES(CYC)) adcs_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.convert_start(convert_start), .sck(sck), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe), .irq(irq));
	adcs_host adcs_host_i (
		.pclk(pclk), .convert_start(convert_start), .sck(sck),
		.serial_data_in(serial_data_in), .sdo_wire(sdo_wire));
	// Verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// One APB transfer, request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("unexpected pready expected 1 seen %b", pready);
			results();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	// Conversion and readout; eg is sck/sdi at the edge, dr and rs are cnv/sdi in conversion and read
	task automatic run(input logic [1:0] eg, input logic [1:0] dr, input logic [1:0] rs, input int n,
		input logic [47:0] up, output logic [31:0] st, output logic [47:0] got);
		adcs_host_i.pins(1'b0, eg[1], eg[0]);
		adcs_host_i.idle(4);
		adcs_host_i.pins(1'b1, eg[1], eg[0]);
		adcs_host_i.idle(2);
		adcs_host_i.pins(dr[1], 1'b0, dr[0]);
		adcs_host_i.idle(CYC + 20); // Host sits out the conversion
		rd(OFS_STATUS, st);
		adcs_host_i.pins(rs[1], 1'b0, rs[0]);
		adcs_host_i.idle(8);
		adcs_host_i.shift(n, up, got);
		adcs_host_i.pins(1'b1, 1'b0, 1'b1);
		adcs_host_i.idle(8);
	endtask
	// Reset values and an unmapped address
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		rd(OFS_STATUS, q);
		`CHK("status", 6'h00, {q[6:2], q[0]});
		`CHK("oe", 1'b0, serial_data_out_oe);
		rd(OFS_SAMPLE, q);
		`CHK("sample", {14'h0, SAMPLE_RESET}, q);
		rd(OFS_IRQ_ENABLE, q);
		`CHK("irq enable", {29'h0, IRQ_EN_RESET}, q);
		apb(1'b0, 8'h18, 32'h0, q, e);
		`CHK("unmapped", 33'h100000000, {e, q});
		$display("done reset");
	endtask
	// Select modes: three-wire and four-wire, start bit off and on
	task automatic t_select();
		logic [31:0] st;
		logic [47:0] g;
		wr(OFS_SAMPLE, {16'h0, CODE});
		run(2'b01, 2'b11, 2'b01, 17, '1, st, g);
		`CHK("mode", 5'h06, st[4:0]);
		`CHK("frame", {CODE, 1'b1}, g[16:0]);
		run(2'b01, 2'b01, 2'b01, 18, '1, st, g);
		`CHK("mode", 5'h16, st[4:0]);
		`CHK("frame", {START_BIT_SEL, CODE, 1'b1}, g[17:0]);
		run(2'b01, 2'b11, 2'b10, 17, '0, st, g);
		`CHK("mode", 5'h06, st[4:0]);
		`CHK("frame", {CODE, 1'b1}, g[16:0]);
		run(2'b01, 2'b10, 2'b10, 18, '0, st, g);
		`CHK("mode", 5'h16, st[4:0]);
		`CHK("frame", {START_BIT_SEL, CODE, 1'b1}, g[17:0]);
		$display("done select");
	endtask
	// Chain mode with upstream data, then with the start bit
	task automatic t_chain();
		logic [31:0] st;
		logic [47:0] g;
		run(2'b00, 2'b10, 2'b00, 32, 48'h00003C5A0000, st, g);
		`CHK("mode", 5'h0E, st[4:0]);
		`CHK("frame", {CODE, 16'h3C5A}, g[31:0]);
		run(2'b10, 2'b10, 2'b00, 17, '0, st, g);
		`CHK("mode", 5'h1E, st[4:0]);
		`CHK("frame", {START_BIT_CHN, CODE}, g[16:0]);
		adcs_host_i.pins(1'b0, 1'b0, 1'b0);
		adcs_host_i.idle(4);
		adcs_host_i.pins(1'b1, 1'b0, 1'b1);
		adcs_host_i.idle(CYC + 20);
		rd(OFS_STATUS, st);
		`CHK("tied", 2'h3, st[3:2]);
		$display("done chain");
	endtask
	// Interrupt raised, masked and cleared
	task automatic t_irq();
		logic [31:0] q;
		logic [47:0] g;
		wr(OFS_IRQ_CLEAR, 32'h7);
		wr(OFS_IRQ_ENABLE, 32'h1);
		run(2'b01, 2'b11, 2'b01, 16, '1, q, g);
		adcs_host_i.idle(2);
		`CHK("irq", 1'b1, irq);
		rd(OFS_IRQ_STATUS, q);
		`CHK("irq status", 32'h7, q);
		wr(OFS_IRQ_ENABLE, 32'h0);
		adcs_host_i.idle(2);
		`CHK("irq masked", 1'b0, irq);
		rd(OFS_IRQ_CLEAR, q);
		`CHK("clear read", 32'h0, q);
		wr(OFS_IRQ_CLEAR, 32'h7);
		rd(OFS_IRQ_STATUS, q);
		`CHK("irq cleared", 32'h0, q);
		$display("done irq");
	endtask
	// Range clamps; overrange wins when both are set
	task automatic t_range();
		logic [31:0] smp [3];
		logic [15:0] ex  [3];
		logic [31:0] q;
		logic [47:0] g;
		smp = '{32'h00012345, 32'h00022345, 32'h00030001};
		ex  = '{CODE_ALL_ONES, CODE_ALL_ZEROS, CODE_ALL_ONES};
		for (int i = 0; i < 3; i++) begin
			wr(OFS_SAMPLE, smp[i]);
			run(2'b01, 2'b11, 2'b01, 16, '1, q, g);
			`CHK("serial code", ex[i], g[15:0]);
			rd(OFS_RESULT, q);
			`CHK("result", {16'h0, ex[i]}, q);
		end
		$display("done range");
	endtask
	// Main sequence
	initial begin
		// Bus idle; host pins at rest: start low, clock low, data input high
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 8'h00;
		pwdata  <= 32'h0;
		adcs_host_i.pins(1'b0, 1'b0, 1'b1);
		repeat (19) @(posedge pclk);
		presetn <= 1'b1;
		adcs_host_i.idle(4);
		t_reset();
		t_select();
		t_chain();
		t_irq();
		t_range();
		results();
	end
	// Cut a hang short
	initial begin
		#1ms;
		mismatches++;
		$display("unexpected run time expected end seen hang");
		results();
	end
endmodule
